// [hdl/cccr_chroma_align.sv]
// chroma-to-luma alignment delay line with cr/cb exchange
`timescale 1ns/1ps
module cccr_chroma_align
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // control
    input  wire logic [2:0]             tap_sel,
    input  wire logic                   swap,
    // pixel stream
    input  wire cccr_pkg::cccr_pix_t    pix_in,
    input  wire logic                   pix_in_valid,
    output      cccr_pkg::cccr_pix_t    pix_out,
    output      logic                   pix_out_valid
);

    logic [19:0]            ch_tap [cccr_pkg::CCCR_TAPS];
    logic [9:0]             lu_tap [3];
    logic [19:0]            ch_sel;
    cccr_pkg::cccr_pix_t    next_pix_out;

    assign ch_tap[0] = {pix_in.cb, pix_in.cr};
    assign lu_tap[0] = pix_in.luma;

    // chroma taps advance only on valid samples, so shifts count pixels
    for (genvar k = 1; k < cccr_pkg::CCCR_TAPS; k++)
    begin : g_ch
        logic [19:0] next_tap;
        assign next_tap = pix_in_valid ? ch_tap[k-1] : ch_tap[k];
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                ch_tap[k] <= 20'h00000;
            else
                ch_tap[k] <= next_tap;
        end
    end

    // luma sits mid-line so chroma can run early as well as late
    for (genvar k = 1; k < 3; k++)
    begin : g_lu
        logic [9:0] next_tap;
        assign next_tap = pix_in_valid ? lu_tap[k-1] : lu_tap[k];
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                lu_tap[k] <= 10'h000;
            else
                lu_tap[k] <= next_tap;
        end
    end

    // tap pick and optional pair exchange
    always_comb
    begin
        ch_sel       = ch_tap[tap_sel];
        next_pix_out = pix_out;
        if (pix_in_valid)
        begin
            next_pix_out.luma = lu_tap[2];
            next_pix_out.cb   = swap ? ch_sel[9:0] : ch_sel[19:10];
            next_pix_out.cr   = swap ? ch_sel[19:10] : ch_sel[9:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pix_out       <= '0;
            pix_out_valid <= 1'b0;
        end
        else
        begin
            pix_out       <= next_pix_out;
            pix_out_valid <= pix_in_valid;
        end
    end

endmodule

// [hdl/cccr_clk_select.sv]
// line-locked clock source and frequency word selection
`timescale 1ns/1ps
module cccr_clk_select
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // settings and tracked values
    input  wire cccr_pkg::cccr_clk_cfg_t cfg,
    input  wire logic [17:0]            auto_freq,
    input  wire logic [2:0]             auto_mode,
    // results
    output      cccr_pkg::cccr_clk_src_t src,
    output      logic [17:0]            freq_word,
    output      logic [2:0]             auto_mode_out,
    output      logic                   auto_mode_apply
);

    cccr_pkg::cccr_clk_src_t    next_src;
    logic [17:0]                next_freq_word;
    logic [2:0]                 next_auto_mode_out;
    logic                       next_auto_mode_apply;

    // crystal wins the source select, then manual over video tracking; word and mode apply follow manual_en alone
    always_comb
    begin
        if (cfg.fix_crystal)
            next_src = cccr_pkg::CCCR_SRC_CRYSTAL;
        else if (cfg.manual_en)
            next_src = cccr_pkg::CCCR_SRC_MANUAL;
        else
            next_src = cccr_pkg::CCCR_SRC_VIDEO;
        next_freq_word       = cfg.manual_en ? cfg.value : auto_freq;
        next_auto_mode_apply = !cfg.manual_en;
        next_auto_mode_out   = cfg.manual_en ? auto_mode_out : auto_mode;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src             <= cccr_pkg::CCCR_SRC_VIDEO;
            freq_word       <= cccr_pkg::CCCR_CLK_WORD_RESET;
            auto_mode_out   <= 3'h0;
            auto_mode_apply <= 1'b0;
        end
        else
        begin
            src             <= next_src;
            freq_word       <= next_freq_word;
            auto_mode_out   <= next_auto_mode_out;
            auto_mode_apply <= next_auto_mode_apply;
        end
    end

endmodule

// [hdl/cccr_regs.sv]
// chroma comb, subcarrier, pixel delay and manual clock register bank
`timescale 1ns/1ps
module cccr_regs
(
    // clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST_N,
    // register port
    input  wire logic [7:0]             REG_ADDR,
    input  wire logic [7:0]             REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output      logic [7:0]             REG_RDATA,
    // pixel stream
    input  wire cccr_pkg::cccr_pix_t    PIX_IN,
    input  wire logic                   PIX_IN_VALID,
    output      cccr_pkg::cccr_pix_t    PIX_OUT,
    output      logic                   PIX_OUT_VALID,
    // tracked values from the decoder core
    input  wire logic [27:0]            AUTO_SC_FREQ,
    input  wire logic [17:0]            AUTO_CLK_FREQ,
    input  wire logic [2:0]             AUTO_CLOCK_MODE_SELECT,
    // comb filter control
    output      logic [1:0]             CHROMA_COMB_SELECT,
    output      logic                   COMB_ADAPT_ENABLE,
    // subcarrier control
    output      logic                   SUBCARRIER_MANUAL_SELECT,
    output      logic [27:0]            SUBCARRIER_FREQ_WORD,
    // line-locked clock control
    output      cccr_pkg::cccr_clk_src_t LINE_CLOCK_SOURCE,
    output      logic [17:0]            LINE_CLOCK_FREQ_WORD,
    output      logic [2:0]             AUTO_CLOCK_MODE_OUT,
    output      logic                   AUTO_CLOCK_MODE_APPLY
);

    // register storage and decode
    logic [7:0]                 reg_q   [cccr_pkg::CCCR_NUM_REGS];
    logic [cccr_pkg::CCCR_NUM_REGS-1:0] wr_hit;
    logic [cccr_pkg::CCCR_NUM_REGS-1:0] rd_hit;

    // applied multi-byte words
    logic [27:0]                subcarrier_freq_value;
    logic [27:0]                next_subcarrier_freq_value;
    logic [17:0]                manual_clock_value;
    logic [17:0]                next_manual_clock_value;

    // set by upper byte writes, cleared by the low
    logic                       sc_pending;
    logic                       next_sc_pending;
    logic                       clk_pending;
    logic                       next_clk_pending;

    // decoded fields
    logic [1:0]                 chroma_comb_select;
    logic                       comb_adapt_enable;
    logic                       subcarrier_manual_select;
    logic [2:0]                 chroma_timing_adjust;
    logic                       chroma_pair_swap;
    logic                       clock_gen_manual_enable;
    logic                       fixed_crystal_output_enable;

    // bad code flags, shown in status
    logic                       comb_code_bad;
    logic                       timing_code_bad;

    // tap index, remapped for bad codes
    logic [2:0]                 tap_sel;
    cccr_pkg::cccr_clk_cfg_t    clk_cfg;

    // control outputs
    logic [1:0]                 next_comb_select;
    logic                       next_comb_adapt;
    logic                       next_sc_manual;
    logic [27:0]                next_sc_word;

    // read path
    logic [7:0]                 status_byte;

    // zero unless a read strobe is seen
    logic [7:0]                 next_rdata;

    // one decoder and one storage byte per register
    for (genvar i = 0; i < cccr_pkg::CCCR_NUM_REGS; i++)
    begin : g_reg
        logic [7:0] next_byte;
        // exact offset match only
        assign wr_hit[i]  = REG_WR && (REG_ADDR == cccr_pkg::CCCR_REG_ADDR[i]);
        assign rd_hit[i]  = REG_RD && (REG_ADDR == cccr_pkg::CCCR_REG_ADDR[i]);
        // reserved bits are stored as written and read back unchanged
        assign next_byte  = wr_hit[i] ? REG_WDATA : reg_q[i];
        always_ff @(posedge SYS_CLK or negedge RST_N)
        begin
            if (!RST_N)
                reg_q[i] <= cccr_pkg::CCCR_REG_RESET[i];
            else
                reg_q[i] <= next_byte;
        end
    end

    // field extraction from the stored bytes
    always_comb
    begin
        chroma_comb_select          = reg_q[cccr_pkg::CCCR_IDX_COMB]
                                      [cccr_pkg::CCCR_COMB_SEL_LSB +: 2];
        comb_adapt_enable           = reg_q[cccr_pkg::CCCR_IDX_COMB]
                                      [cccr_pkg::CCCR_COMB_ADAPT_BIT];
        subcarrier_manual_select    = reg_q[cccr_pkg::CCCR_IDX_SC1]
                                      [cccr_pkg::CCCR_SC_MAN_BIT];
        chroma_timing_adjust        = reg_q[cccr_pkg::CCCR_IDX_PIX]
                                      [cccr_pkg::CCCR_CTA_LSB +: 3];
        chroma_pair_swap            = reg_q[cccr_pkg::CCCR_IDX_PIX]
                                      [cccr_pkg::CCCR_SWAP_BIT];
        clock_gen_manual_enable     = reg_q[cccr_pkg::CCCR_IDX_CLK1]
                                      [cccr_pkg::CCCR_CLK_MAN_BIT];
        fixed_crystal_output_enable = reg_q[cccr_pkg::CCCR_IDX_CLK1]
                                      [cccr_pkg::CCCR_FIX_XTAL_BIT];
    end

    // invalid codes fall back to the neutral setting instead of garbage
    always_comb
    begin
        comb_code_bad   = (chroma_comb_select == cccr_pkg::CCCR_COMB_INVALID);
        timing_code_bad = (chroma_timing_adjust == cccr_pkg::CCCR_CTA_LOW_BAD) ||
                          (chroma_timing_adjust == cccr_pkg::CCCR_CTA_HIGH_BAD);
        // bad code keeps chroma on luma
        if (timing_code_bad)
            tap_sel = cccr_pkg::CCCR_CTA_NO_SHIFT - cccr_pkg::CCCR_CTA_TAP_BASE;
        else
            tap_sel = chroma_timing_adjust - cccr_pkg::CCCR_CTA_TAP_BASE;
    end

    // multi-byte words apply on the low byte write so the core never sees
    // a half-updated frequency; upper bytes must be written first
    always_comb
    begin
        next_subcarrier_freq_value = subcarrier_freq_value;
        next_sc_pending            = sc_pending;
        // low byte write applies the word
        if (wr_hit[cccr_pkg::CCCR_IDX_SC4])
        begin
            next_subcarrier_freq_value = {reg_q[cccr_pkg::CCCR_IDX_SC1][3:0],
                                          reg_q[cccr_pkg::CCCR_IDX_SC2],
                                          reg_q[cccr_pkg::CCCR_IDX_SC3],
                                          REG_WDATA};
            next_sc_pending            = 1'b0;
        end
        // upper bytes only mark it stale
        else if (wr_hit[cccr_pkg::CCCR_IDX_SC1] || wr_hit[cccr_pkg::CCCR_IDX_SC2] ||
                 wr_hit[cccr_pkg::CCCR_IDX_SC3])
            next_sc_pending = 1'b1;
    end

    // same staging for the manual clock word
    always_comb
    begin
        next_manual_clock_value = manual_clock_value;
        next_clk_pending        = clk_pending;
        // only the value is staged
        if (wr_hit[cccr_pkg::CCCR_IDX_CLK3])
        begin
            next_manual_clock_value = {reg_q[cccr_pkg::CCCR_IDX_CLK1][1:0],
                                       reg_q[cccr_pkg::CCCR_IDX_CLK2],
                                       REG_WDATA};
            next_clk_pending        = 1'b0;
        end
        // same stale marking
        else if (wr_hit[cccr_pkg::CCCR_IDX_CLK1] || wr_hit[cccr_pkg::CCCR_IDX_CLK2])
            next_clk_pending = 1'b1;
    end

    // staged words and flags
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            subcarrier_freq_value <= cccr_pkg::CCCR_SC_WORD_RESET;
            manual_clock_value    <= cccr_pkg::CCCR_CLK_WORD_RESET;
            sc_pending            <= 1'b0;
            clk_pending           <= 1'b0;
        end
        else
        begin
            subcarrier_freq_value <= next_subcarrier_freq_value;
            manual_clock_value    <= next_manual_clock_value;
            sc_pending            <= next_sc_pending;
            clk_pending           <= next_clk_pending;
        end
    end

    // comb and subcarrier controls toward the decoder core
    always_comb
    begin
        next_comb_select = comb_code_bad ? cccr_pkg::CCCR_COMB_NONE
                                         : chroma_comb_select;
        next_comb_adapt  = comb_adapt_enable;
        next_sc_manual   = subcarrier_manual_select;
        next_sc_word     = subcarrier_manual_select ? subcarrier_freq_value
                                                    : AUTO_SC_FREQ;
    end

    // one clean change per write
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CHROMA_COMB_SELECT       <= cccr_pkg::CCCR_COMB_NONE;
            COMB_ADAPT_ENABLE        <= 1'b0;
            SUBCARRIER_MANUAL_SELECT <= 1'b0;
            SUBCARRIER_FREQ_WORD     <= cccr_pkg::CCCR_SC_WORD_RESET;
        end
        else
        begin
            CHROMA_COMB_SELECT       <= next_comb_select;
            COMB_ADAPT_ENABLE        <= next_comb_adapt;
            SUBCARRIER_MANUAL_SELECT <= next_sc_manual;
            SUBCARRIER_FREQ_WORD     <= next_sc_word;
        end
    end

    // clock generator settings bundle
    // value is the staged word
    assign clk_cfg.fix_crystal = fixed_crystal_output_enable;
    assign clk_cfg.manual_en   = clock_gen_manual_enable;
    assign clk_cfg.value       = manual_clock_value;

    // clock source and frequency selection
    // crystal over manual priority inside
    cccr_clk_select u_clk_select
    (
        .clk             (SYS_CLK),
        .rst_n           (RST_N),
        .cfg             (clk_cfg),
        .auto_freq       (AUTO_CLK_FREQ),
        .auto_mode       (AUTO_CLOCK_MODE_SELECT),
        .src             (LINE_CLOCK_SOURCE),
        .freq_word       (LINE_CLOCK_FREQ_WORD),
        .auto_mode_out   (AUTO_CLOCK_MODE_OUT),
        .auto_mode_apply (AUTO_CLOCK_MODE_APPLY)
    );

    // chroma timing and pair exchange on the pixel stream
    // tap_sel never holds a bad code
    cccr_chroma_align u_chroma_align
    (
        .clk           (SYS_CLK),
        .rst_n         (RST_N),
        .tap_sel       (tap_sel),
        .swap          (chroma_pair_swap),
        .pix_in        (PIX_IN),
        .pix_in_valid  (PIX_IN_VALID),
        .pix_out       (PIX_OUT),
        .pix_out_valid (PIX_OUT_VALID)
    );

    // live status: bad codes, pending flags for the staged words, current clock source
    always_comb
    begin
        // bits 7:6 read as zero
        status_byte      = 8'h00;
        status_byte[0]   = comb_code_bad;
        status_byte[1]   = timing_code_bad;
        status_byte[2]   = sc_pending;
        status_byte[3]   = clk_pending;
        status_byte[5:4] = LINE_CLOCK_SOURCE;
    end

    // read mux; data stands only in the cycle after the strobe,
    // unmapped offsets read as zero
    always_comb
    begin
        next_rdata = 8'h00;
        if (REG_RD)
        begin
            if (REG_ADDR == cccr_pkg::CCCR_ADDR_STATUS)
                next_rdata = status_byte;
            for (int j = 0; j < cccr_pkg::CCCR_NUM_REGS; j++)
            begin
                if (rd_hit[j])
                    next_rdata = reg_q[j];
            end
        end
    end

    // zero outside its cycle
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            REG_RDATA <= 8'h00;
        else
            REG_RDATA <= next_rdata;
    end

endmodule

// [inc/cccr_pkg.sv]
// shared constants and types for the chroma and clock control register bank
package cccr_pkg;

    // register bank geometry
    localparam int              CCCR_NUM_REGS   = 9;
    localparam int              CCCR_IDX_W      = 4;
    localparam int              CCCR_TAPS       = 6;

    // register indices into the bank
    localparam int              CCCR_IDX_COMB   = 0;
    localparam int              CCCR_IDX_SC1    = 1;
    localparam int              CCCR_IDX_SC2    = 2;
    localparam int              CCCR_IDX_SC3    = 3;
    localparam int              CCCR_IDX_SC4    = 4;
    localparam int              CCCR_IDX_PIX    = 5;
    localparam int              CCCR_IDX_CLK1   = 6;
    localparam int              CCCR_IDX_CLK2   = 7;
    localparam int              CCCR_IDX_CLK3   = 8;

    // byte offsets, in index order
    localparam logic [7:0]      CCCR_REG_ADDR [CCCR_NUM_REGS] = '{
        8'h19, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A
    };
    // read-only status register
    localparam logic [7:0]      CCCR_ADDR_STATUS = 8'h2F;

    // reset values, in index order
    localparam logic [7:0]      CCCR_REG_RESET [CCCR_NUM_REGS] = '{
        8'h00, 8'hE0, 8'h00, 8'h00, 8'h00, 8'h58, 8'h3C, 8'h00, 8'h00
    };
    localparam logic [27:0]     CCCR_SC_WORD_RESET  = 28'h0000000;
    localparam logic [17:0]     CCCR_CLK_WORD_RESET = 18'h00000;

    // field positions
    localparam int              CCCR_COMB_SEL_LSB   = 2;
    localparam int              CCCR_COMB_ADAPT_BIT = 4;
    localparam int              CCCR_SC_MAN_BIT     = 4;
    localparam int              CCCR_CTA_LSB        = 3;
    localparam int              CCCR_SWAP_BIT       = 7;
    localparam int              CCCR_CLK_MAN_BIT    = 6;
    localparam int              CCCR_FIX_XTAL_BIT   = 7;

    // comb modes
    localparam logic [1:0]      CCCR_COMB_NONE      = 2'h0;
    localparam logic [1:0]      CCCR_COMB_ONE_LINE  = 2'h1;
    localparam logic [1:0]      CCCR_COMB_TWO_LINE  = 2'h2;
    localparam logic [1:0]      CCCR_COMB_INVALID   = 2'h3;

    // chroma timing codes
    localparam logic [2:0]      CCCR_CTA_LOW_BAD    = 3'h0;
    localparam logic [2:0]      CCCR_CTA_NO_SHIFT   = 3'h3;
    localparam logic [2:0]      CCCR_CTA_HIGH_BAD   = 3'h7;
    localparam logic [2:0]      CCCR_CTA_TAP_BASE   = 3'h1;

    // source of the line-locked clock outputs
    typedef enum logic [1:0] {
        CCCR_SRC_VIDEO,
        CCCR_SRC_MANUAL,
        CCCR_SRC_CRYSTAL
    } cccr_clk_src_t;

    // one pixel with its own chroma pair
    typedef struct packed {
        logic [9:0]             luma;
        logic [9:0]             cb;
        logic [9:0]             cr;
    } cccr_pix_t;

    // clock generator settings
    typedef struct packed {
        logic                   fix_crystal;
        logic                   manual_en;
        logic [17:0]            value;
    } cccr_clk_cfg_t;

endpackage

// [tb/cccr_regs_checker.sv]
// port assertions for the chroma and clock control register bank
`timescale 1ns/1ps
module cccr_regs_checker
(
    // clock and reset
    input  wire logic                    SYS_CLK,
    input  wire logic                    RST_N,
    // register port
    input  wire logic [7:0]              REG_ADDR,
    input  wire logic [7:0]              REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    input  wire logic [7:0]              REG_RDATA,
    // pixel stream
    input  wire logic                    PIX_IN_VALID,
    input  wire cccr_pkg::cccr_pix_t     PIX_OUT,
    input  wire logic                    PIX_OUT_VALID,
    // tracked values
    input  wire logic [27:0]             AUTO_SC_FREQ,
    input  wire logic [17:0]             AUTO_CLK_FREQ,
    input  wire logic [2:0]              AUTO_CLOCK_MODE_SELECT,
    // controls
    input  wire logic [1:0]              CHROMA_COMB_SELECT,
    input  wire logic                    COMB_ADAPT_ENABLE,
    input  wire logic                    SUBCARRIER_MANUAL_SELECT,
    input  wire logic [27:0]             SUBCARRIER_FREQ_WORD,
    input  wire cccr_pkg::cccr_clk_src_t LINE_CLOCK_SOURCE,
    input  wire logic [17:0]             LINE_CLOCK_FREQ_WORD,
    input  wire logic [2:0]              AUTO_CLOCK_MODE_OUT,
    input  wire logic                    AUTO_CLOCK_MODE_APPLY
);
    // single domain, so one clocking and one reset serve every property
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    // control fields land two edges after the write is taken
    a_comb_code: assert property (REG_WR && REG_ADDR == 8'h19 |-> ##2
        CHROMA_COMB_SELECT == (&$past(REG_WDATA[3:2], 2) ? 2'h0 : $past(REG_WDATA[3:2], 2)))
        else $error("comb select wrong after write");
    a_comb_adapt: assert property (REG_WR && REG_ADDR == 8'h19 |-> ##2
        COMB_ADAPT_ENABLE == $past(REG_WDATA[4], 2))
        else $error("comb adapt wrong after write");
    a_sc_select: assert property (REG_WR && REG_ADDR == 8'h23 |-> ##2
        SUBCARRIER_MANUAL_SELECT == $past(REG_WDATA[4], 2))
        else $error("subcarrier select wrong after write");
    a_clk_source: assert property (REG_WR && REG_ADDR == 8'h28 |-> ##2
        LINE_CLOCK_SOURCE == ($past(REG_WDATA[7], 2) ? cccr_pkg::CCCR_SRC_CRYSTAL :
        $past(REG_WDATA[6], 2) ? cccr_pkg::CCCR_SRC_MANUAL : cccr_pkg::CCCR_SRC_VIDEO))
        else $error("clock source wrong after write");
    a_apply_flag: assert property (REG_WR && REG_ADDR == 8'h28 |-> ##2
        AUTO_CLOCK_MODE_APPLY == !$past(REG_WDATA[6], 2))
        else $error("auto mode apply wrong after write");
    // automatic words pass through while manual is off; the auto mode output is held while it is on
    a_sc_auto: assert property (!SUBCARRIER_MANUAL_SELECT [*3] |->
        SUBCARRIER_FREQ_WORD == $past(AUTO_SC_FREQ))
        else $error("subcarrier word not tracking");
    a_clk_auto: assert property (AUTO_CLOCK_MODE_APPLY [*2] |->
        LINE_CLOCK_FREQ_WORD == $past(AUTO_CLK_FREQ))
        else $error("clock word not tracking");
    a_mode_hold: assert property (!AUTO_CLOCK_MODE_APPLY [*2] |->
        $stable(AUTO_CLOCK_MODE_OUT))
        else $error("auto mode moved in manual");
    // read data is one cycle wide, and the stream keeps its cadence
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its cycle");
    a_pix_hold: assert property (!$past(PIX_IN_VALID) |-> $stable(PIX_OUT) && !PIX_OUT_VALID)
        else $error("pixel output moved without input");
endmodule

// [tb/cccr_regs_test.sv]
// self-checking bench for the chroma and clock control register bank
`timescale 1ns/1ps
module cccr_regs_test;
    // stimulus
    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic [7:0]              addr = 8'h00;
    logic [7:0]              wdata = 8'h00;
    logic                    wr = 1'b0;
    logic                    rd = 1'b0;
    cccr_pkg::cccr_pix_t     pix_in = '0;
    logic                    pix_vld = 1'b0;
    logic [27:0]             auto_sc = 28'h1234567;
    logic [17:0]             auto_clk = 18'h2ABCD;
    logic [2:0]              auto_mode = 3'h2;
    // observed outputs
    logic [7:0]              rdata;
    cccr_pkg::cccr_pix_t     pix_out;
    logic                    pix_out_vld;
    logic [1:0]              comb_sel;
    logic                    adapt;
    logic                    sc_sel;
    logic [27:0]             sc_word;
    cccr_pkg::cccr_clk_src_t clk_src;
    logic [17:0]             clk_word;
    logic [2:0]              mode_out;
    logic                    mode_apply;
    // bookkeeping
    int                      failures = 0;
    int                      n_compared = 0;
    logic [7:0]              d;
    cccr_pkg::cccr_pix_t     e;
    cccr_pkg::cccr_pix_t     c;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    cccr_regs i_cccr_regs
    (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PIX_IN(pix_in),
        .PIX_IN_VALID(pix_vld), .PIX_OUT(pix_out), .PIX_OUT_VALID(pix_out_vld),
        .AUTO_SC_FREQ(auto_sc), .AUTO_CLK_FREQ(auto_clk), .AUTO_CLOCK_MODE_SELECT(auto_mode),
        .CHROMA_COMB_SELECT(comb_sel), .COMB_ADAPT_ENABLE(adapt),
        .SUBCARRIER_MANUAL_SELECT(sc_sel), .SUBCARRIER_FREQ_WORD(sc_word),
        .LINE_CLOCK_SOURCE(clk_src), .LINE_CLOCK_FREQ_WORD(clk_word),
        .AUTO_CLOCK_MODE_OUT(mode_out), .AUTO_CLOCK_MODE_APPLY(mode_apply)
    );

    // register port cycles; a gap cycle avoids double assignment of a strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // controls are updated two edges after the write is taken
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // sample k carries its index in every field so pairing is visible
    function automatic cccr_pkg::cccr_pix_t px(input int k);
        return {10'(k), 10'(k) | 10'h100, 10'(k) | 10'h200};
    endfunction

    // main sequence
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < cccr_pkg::CCCR_NUM_REGS; i++)
        begin
            rd_reg(cccr_pkg::CCCR_REG_ADDR[i], d);
            chk("reset value", d, cccr_pkg::CCCR_REG_RESET[i]);
        end
        rd_reg(8'h30, d);
        chk("unmapped read", d, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(8'h19, {3'h0, m[0], m[1:0], 2'h0});
            settle();
            chk("comb select", comb_sel, (m == 3) ? 2'h0 : m[1:0]);
            chk("comb adapt", adapt, m[0]);
        end
        wr_reg(8'h23, 8'hFA);
        wr_reg(8'h24, 8'hBC);
        wr_reg(8'h25, 8'hDE);
        wr_reg(8'h26, 8'hF1);
        settle();
        chk("sc word", sc_word, 28'hABCDEF1);
        wr_reg(8'h23, 8'hEA);
        settle();
        chk("sc auto word", sc_word, auto_sc);
        wr_reg(8'h28, 8'h7E);
        wr_reg(8'h29, 8'h34);
        wr_reg(8'h2A, 8'h56);
        @(posedge sys_clk);
        auto_mode <= 3'h5;
        settle();
        chk("manual source", clk_src, cccr_pkg::CCCR_SRC_MANUAL);
        chk("manual word", clk_word, 18'h23456);
        chk("mode held", mode_out, 3'h2);
        wr_reg(8'h28, 8'hFE);
        settle();
        chk("crystal source", clk_src, cccr_pkg::CCCR_SRC_CRYSTAL);
        wr_reg(8'h28, 8'h3C);
        settle();
        chk("video word", clk_word, auto_clk);
        chk("mode follows", mode_out, 3'h5);
        // timing codes 001 to 111, swap on odd codes
        for (int t = 1; t < 8; t++)
        begin
            wr_reg(8'h27, {t[0], 1'b1, t[2:0], 3'h0});
            for (int k = 0; k < 14; k++)
            begin
                @(posedge sys_clk);
                pix_in <= px(k);
                pix_vld <= 1'b1;
                #1;
                e = px(k - 3);
                c = px(k - (t == 7 ? 3 : t));
                e.cb = t[0] ? c.cr : c.cb;
                e.cr = t[0] ? c.cb : c.cr;
                if (k > 9)
                    chk("pixel out", pix_out, e);
            end
            @(posedge sys_clk);
            pix_vld <= 1'b0;
        end
        rd_reg(8'h2F, d);
        chk("status", d, 8'h0F);
        rd_reg(8'h27, d);
        chk("readback", d, 8'hF8);
        give_verdict();
    end

    // watchdog well beyond the expected run
    initial
    begin
        #40000;
        failures++;
        give_verdict();
    end
endmodule

bind cccr_regs cccr_regs_checker i_cccr_regs_checker (.SYS_CLK, .RST_N, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA, .PIX_IN_VALID, .PIX_OUT, .PIX_OUT_VALID, .AUTO_SC_FREQ,
    .AUTO_CLK_FREQ, .AUTO_CLOCK_MODE_SELECT, .CHROMA_COMB_SELECT, .COMB_ADAPT_ENABLE,
    .SUBCARRIER_MANUAL_SELECT, .SUBCARRIER_FREQ_WORD, .LINE_CLOCK_SOURCE,
    .LINE_CLOCK_FREQ_WORD, .AUTO_CLOCK_MODE_OUT, .AUTO_CLOCK_MODE_APPLY);
